// ===== logic/dca_pkg.sv
/*
  Constants and state layout shared by the dual chip arbiter.
  Assumes a single 40 MHz clock and a 3-bit permission code bus.
*/
package dca_pkg;

  // ----------------------------------------------------------------
  // permission codes seen on the bus
  // ----------------------------------------------------------------
  localparam int CODE_W = 3;
  localparam logic [2:0] CODE_HOST_CONTROL = 3'h0;
  localparam logic [2:0] CODE_SHAR_RETURN = 3'h1;
  localparam logic [2:0] CODE_NONE_ALLOWED = 3'h2;
  localparam logic [2:0] CODE_ONE_CYCLE = 3'h3;
  localparam logic [2:0] CODE_NO_IO = 3'h4;
  localparam logic [2:0] CODE_ANY_TRANS = 3'h5;
  localparam logic [2:0] CODE_RET_ONLY = 3'h6;
  localparam logic [2:0] CODE_ATOMIC = 3'h7;

  // ----------------------------------------------------------------
  // pointer values and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] PTR_INIT_ID0 = 2'h0;
  localparam logic [1:0] PTR_INIT_ID1 = 2'h2;
  localparam logic [1:0] PTR_STEP = 2'h1;
  localparam int SYNC_STAGES = 2;
  localparam int AGENT_ID_W = 3;
  localparam int CHIP_SEL_BIT = 2;

  // ----------------------------------------------------------------
  // arbiter state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] rr_ptr;
    logic [1:0] at_ptr;
    logic [1:0] pick;
    logic idle;
    logic drive;
    logic follow;
    logic dflt;
    logic [1:0] arb_out;
    logic excl_out;
    logic backoff;
    logic bo_armed;
    logic seq_on;
    logic seq_done;
  } dca_state_t;

  localparam dca_state_t STATE_RESET = '0;

endpackage : dca_pkg

// ===== logic/dca_sync.sv
/*
  Two-stage synchroniser for a bundle of level signals.
  Assumes each bit is a level that may change at any time.
*/
`timescale 1ns/1ps
module dca_sync #(
  parameter int WIDTH = 1
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  import dca_pkg::*;

  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end

endmodule : dca_sync

// ===== logic/dca_arbiter.sv
/*
  Arbitration logic for one of two mirrored bridge chips on a shared bus:
  round-robin pointer for return-only / single-cycle codes and an atomic
  pointer driven by exclusive-request lines traded with the peer chip.
  Assumes the peer chip runs this same logic and that its arbitration and
  exclusive lines arrive as asynchronous pins.
*/
// Summary of operation
// RL1: round-robin pointer: chip bit, adapter bit
// RL2: power-on values 00 or 10 by strap
// RL3: evaluate only in relevant round-robin phases
// RL4: no requester: no winner, pointer holds
// RL5: any requester wins; misfit drives idle
// RL6: every round-robin win advances pointer
// RL7: winner sets picks, idle, drive, claim
// RL8: adapter exclusive request raises outgoing line
// RL9: peer exclusive line feeds atomic decisions
// RL10: higher atomic priority keeps winning sequence
// RL11: loser withdraws until over plus any-trans
// RL12: atomic pointer: chip bit, adapter bit
// RL13: atomic pointer moves only at end/start
// RL14: sequence over: atomic code, no lines
// RL15: mistimed atomic arbitration drives idle
// RL16: picks show winner; none means idle
// RL17: follow-cycle claim on every win
// RL18: pick holds until adapter done pulse
// RL19: rotation goes to winner plus one
// RL20: atomic pointer starts like round-robin pointer
`timescale 1ns/1ps
module dca_arbiter (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic power_stable,
  input wire logic [dca_pkg::AGENT_ID_W-1:0] agent_id,
  input wire logic [dca_pkg::CODE_W-1:0] bus_permission_code,
  input wire logic long_trans,
  input wire logic [1:0] adapter_req,
  input wire logic [1:0] adapter_excl_req,
  input wire logic [1:0] adapter_can_issue,
  input wire logic [1:0] adapter_done,
  input wire logic [1:0] peer_arb_req,
  input wire logic peer_excl_req,
  output logic adapter0_pick,
  output logic adapter1_pick,
  output logic adapter_idle,
  output logic bus_drive_en,
  output logic follow_cycle_claim,
  output logic [1:0] arb_req_out,
  output logic excl_req_out
);
  import dca_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // first set request at or after the pointer, cyclically
  function automatic logic [1:0] pick_first(input logic [3:0] req, input logic [1:0] ptr);
    logic [1:0] idx;
    logic [1:0] res;
    res = ptr;
    for (int i = 3; i >= 0; i--) begin
      idx = ptr + 2'(i);
      if (req[idx]) begin
        res = idx;
      end
    end
    return res;
  endfunction : pick_first

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  logic pwr_s;
  logic chip_id_s;
  logic [CODE_W-1:0] code_s;
  logic long_s;
  logic [1:0] peer_req_s;
  logic peer_ex_s;
  logic [1:0] own_req_d;
  logic own_ex_d;

  // pins from the bus and the peer chip
  dca_sync #(.WIDTH(CODE_W + 6)) u_pin_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .d({power_stable, agent_id[CHIP_SEL_BIT], bus_permission_code, long_trans, peer_arb_req, peer_excl_req}),
    .q({pwr_s, chip_id_s, code_s, long_s, peer_req_s, peer_ex_s})
  );

  // own outgoing lines delayed by the same amount, so both chips decide on identical views
  dca_sync #(.WIDTH(3)) u_own_delay (
    .mclk(mclk),
    .rst_b(rst_b),
    .d({arb_req_out, excl_req_out}),
    .q({own_req_d, own_ex_d})
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dca_state_t st_reg;
  dca_state_t st_next;

  logic is_atomic;
  logic rr_phase;
  logic at_phase;
  logic seq_over;
  logic [3:0] rr_req;
  logic [3:0] ex_req;
  logic [1:0] win;
  logic local_busy;
  logic [1:0] own_req_m;
  logic [1:0] init_val;

  always_comb begin
    st_next = st_reg;
    is_atomic = (code_s == CODE_ATOMIC);
    local_busy = (st_reg.pick != 2'h0) || st_reg.idle;
    // the delayed copy of our own lines lags the win, so mask it while a local win still runs
    own_req_m = own_req_d & {2{!local_busy}};
    // index 0,1 local adapters, 2,3 peer adapters
    rr_req = {peer_req_s, own_req_m}; // RL1
    ex_req = {peer_ex_s & peer_req_s[1], peer_ex_s & ~peer_req_s[1], adapter_excl_req & {2{own_ex_d}}};
    rr_phase = pwr_s && (code_s == CODE_RET_ONLY || code_s == CODE_ONE_CYCLE)
               && !long_s && !st_reg.dflt; // RL3
    at_phase = pwr_s && is_atomic && !long_s && !st_reg.follow;
    seq_over = is_atomic && !own_ex_d && !peer_ex_s; // RL14
    win = pick_first(rr_req, st_reg.rr_ptr); // RL1
    init_val = chip_id_s ? PTR_INIT_ID1 : PTR_INIT_ID0;
    st_next.follow = 1'b0;
    st_next.dflt = 1'b0;

    // release a finished transfer; an idle win ends after its follow cycle
    if ((st_reg.pick[0] && adapter_done[0]) || (st_reg.pick[1] && adapter_done[1])) begin
      st_next.pick = 2'h0; // RL18
      st_next.drive = 1'b0; // RL18
    end
    if (st_reg.idle && !st_reg.follow) begin
      st_next.idle = 1'b0;
      st_next.drive = 1'b0;
    end

    if (!pwr_s) begin
      // power not yet stable: hold the mirrored power-on values
      st_next.rr_ptr = init_val; // RL2
      st_next.at_ptr = init_val; // RL20
    end else if (rr_phase && rr_req != 4'h0) begin // RL4
      st_next.rr_ptr = win + PTR_STEP; // RL6 RL19
      st_next.dflt = (code_s == CODE_RET_ONLY);
      if (!win[1]) begin
        st_next.drive = 1'b1; // RL7
        st_next.follow = 1'b1; // RL17
        // misfit or premature atomic request: idle instead of a transaction
        if (!adapter_can_issue[win[0]] || adapter_excl_req[win[0]]) begin
          st_next.idle = 1'b1; // RL5 RL15 RL16
        end else begin
          st_next.pick = win[0] ? 2'h2 : 2'h1; // RL7 RL16
        end
      end
    end else if (at_phase && (st_reg.seq_done || seq_over)) begin
      // code still atomic after the sequence: any local arbitration idles
      if (own_req_m != 2'h0) begin
        st_next.idle = 1'b1; // RL15
        st_next.drive = 1'b1;
        st_next.follow = 1'b1; // RL17
      end
    end else if (at_phase && !st_reg.at_ptr[1] && own_req_m[st_reg.at_ptr[0]]) begin // RL12
      // local owner keeps winning the atomic code
      st_next.drive = 1'b1; // RL10
      st_next.follow = 1'b1; // RL17
      if (adapter_can_issue[st_reg.at_ptr[0]]) begin
        st_next.pick = st_reg.at_ptr[0] ? 2'h2 : 2'h1; // RL10 RL16
      end else begin
        st_next.idle = 1'b1; // RL16
      end
    end

    // no new win while a local transfer is still running
    if (local_busy || st_next.pick != 2'h0 || st_next.idle) begin
      st_next.arb_out = 2'h0;
    end else begin
      st_next.arb_out = adapter_req;
    end

    // atomic pointer and sequence tracking
    if (pwr_s) begin
      if (is_atomic) begin
        if (st_reg.seq_on && seq_over) begin
          st_next.at_ptr = st_reg.at_ptr + PTR_STEP; // RL13 RL19
          st_next.seq_on = 1'b0;
          st_next.seq_done = 1'b1;
          st_next.bo_armed = st_reg.backoff;
        end else if (!st_reg.seq_done && !seq_over) begin
          st_next.seq_on = 1'b1; // pointer stays fixed here, RL13
        end
      end else begin
        st_next.seq_done = 1'b0;
        if (!st_reg.seq_on && ex_req != 4'h0) begin
          st_next.at_ptr = pick_first(ex_req, st_reg.at_ptr); // RL13 RL9 RL12
        end
      end
    end

    // both lines up and the peer holds atomic priority: withdraw
    if (own_ex_d && peer_ex_s && st_reg.at_ptr[1] && pwr_s) begin
      st_next.backoff = 1'b1; // RL11 RL9
    end
    if (st_reg.seq_on && seq_over && st_reg.backoff) begin
      st_next.bo_armed = 1'b1;
    end
    if (st_reg.bo_armed && code_s == CODE_ANY_TRANS) begin
      st_next.backoff = 1'b0; // RL11
      st_next.bo_armed = 1'b0;
    end
    st_next.excl_out = (adapter_excl_req != 2'h0) && !st_next.backoff; // RL8
  end

  // single state register; reset takes constants only, strap loads later
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from the state register
  // ----------------------------------------------------------------
  assign adapter0_pick = st_reg.pick[0];
  assign adapter1_pick = st_reg.pick[1];
  assign adapter_idle = st_reg.idle;
  assign bus_drive_en = st_reg.drive;
  assign follow_cycle_claim = st_reg.follow;
  assign arb_req_out = st_reg.arb_out;
  assign excl_req_out = st_reg.excl_out;

endmodule : dca_arbiter

// ===== verif/dca_arbiter_asserts.sv
/* checker on the arbiter's ports, bound to every dca_arbiter.
   assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ps
module dca_arbiter_asserts (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic power_stable,
  input wire logic [1:0] adapter_excl_req,
  input wire logic [1:0] adapter_done,
  input wire logic adapter0_pick,
  input wire logic adapter1_pick,
  input wire logic adapter_idle,
  input wire logic bus_drive_en,
  input wire logic follow_cycle_claim,
  input wire logic excl_req_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // an idle win fills the win cycle and the follow cycle
  sequence s_idle_start; $rose(adapter_idle); endsequence
  sequence s_idle_pair; adapter_idle ##1 adapter_idle; endsequence
  a_pick_single: assert property (!(adapter0_pick && adapter1_pick)) else $error("two picks");
  a_win_drive: assert property ((adapter0_pick || adapter1_pick || adapter_idle) |-> bus_drive_en)
    else $error("win without drive");
  a_follow_pulse: assert property (follow_cycle_claim |=> !follow_cycle_claim) else $error("claim long");
  a_win_follow: assert property ($rose(bus_drive_en) |-> follow_cycle_claim) else $error("no claim");
  a_excl_cause: assert property (excl_req_out |-> $past(|adapter_excl_req)) else $error("stray excl");
  a_done_release: assert property ((adapter_done[0] && adapter0_pick) |=> !adapter0_pick)
    else $error("pick held");
  a_idle_two: assert property (s_idle_start |-> s_idle_pair) else $error("idle short");
  a_power_quiet: assert property (!power_stable [*5] |-> !$rose(bus_drive_en)) else $error("unpowered win");
endmodule : dca_arbiter_asserts
bind dca_arbiter dca_arbiter_asserts u_chk (.mclk(mclk), .rst_b(rst_b), .power_stable(power_stable),
  .adapter_excl_req(adapter_excl_req), .adapter_done(adapter_done), .adapter0_pick(adapter0_pick),
  .adapter1_pick(adapter1_pick), .adapter_idle(adapter_idle), .bus_drive_en(bus_drive_en),
  .follow_cycle_claim(follow_cycle_claim), .excl_req_out(excl_req_out));

// ===== verif/dca_peer_model.sv
/* stand-in for the peer chip's outgoing arbitration and exclusive lines.
   assumes the bench tells it what the peer wants each cycle. */
`timescale 1ns/1ps
module dca_peer_model (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [1:0] want_arb,
  input wire logic want_excl,
  output logic [1:0] peer_arb_req,
  output logic peer_excl_req
);
  // lines launch off the edge, so the arbiter must resync them
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      peer_arb_req <= '0;
      peer_excl_req <= 1'b0;
    end else begin
      peer_arb_req <= want_arb;
      peer_excl_req <= want_excl;
    end
  end
endmodule : dca_peer_model

// ===== verif/tb_top.sv
/* bench for dca_arbiter: pointer model against observed wins.
   assumes dca_pkg code encoding and the peer model beside it. */
`timescale 1ns/1ps
module tb_top;
  import dca_pkg::*;
  logic mclk = 0, rst_b = 0, power_stable = 0, long_trans = 0, want_excl = 0;
  logic [2:0] agent_id = '0, code = '0;
  logic [1:0] req = '0, excl = '0, can_issue = '0, done = '0, want_arb = '0, p_arb, a_out;
  logic p_excl, pick0, pick1, idle, drive, follow, x_out, won;
  logic [31:0] lfsr = 32'h52ca952d;
  int err_total = 0, n_checks = 0, ptr, w, k;
  initial forever #12.5 mclk = ~mclk;
  dca_peer_model peer (.mclk(mclk), .rst_b(rst_b), .want_arb(want_arb), .want_excl(want_excl),
    .peer_arb_req(p_arb), .peer_excl_req(p_excl));
  dca_arbiter dut (.mclk(mclk), .rst_b(rst_b), .power_stable(power_stable), .agent_id(agent_id),
    .bus_permission_code(code), .long_trans(long_trans), .adapter_req(req), .adapter_excl_req(excl),
    .adapter_can_issue(can_issue), .adapter_done(done), .peer_arb_req(p_arb), .peer_excl_req(p_excl),
    .adapter0_pick(pick0), .adapter1_pick(pick1), .adapter_idle(idle), .bus_drive_en(drive),
    .follow_cycle_claim(follow), .arb_req_out(a_out), .excl_req_out(x_out));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk
  // inputs always change 2 ns after the edge
  task automatic tick;
    @(posedge mclk);
    #2;
  endtask : tick
  task automatic print_verdict;
    if (err_total == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // pointer walk over every code below atomic
  // ----------------------------------------
  initial begin
    for (int r = 0; r < 4; r++) begin
      lfsr = nxt(lfsr);
      agent_id = lfsr[2:0];
      rst_b = 0;
      power_stable = 0;
      repeat (6) tick;
      rst_b = 1;
      repeat (3) tick;
      power_stable = 1;
      repeat (4) tick;
      ptr = agent_id[2] ? 2 : 0;
      for (int c = 0; c < 7; c++) begin
        lfsr = nxt(lfsr);
        code = c[2:0];
        long_trans = lfsr[0];
        can_issue = lfsr[2:1];
        want_arb = (c == 3 || c == 6) ? 2'b00 : lfsr[4:3]; // peer noise only where nobody may win
        req = 2'b11;
        won = 0;
        for (k = 0; k < 12 && !won; k++) begin
          tick;
          won = pick0 | pick1 | idle;
        end
        code = CODE_NONE_ALLOWED;
        req = 2'b00;
        want_arb = 2'b00;
        chk("win", won, (c == 3 || c == 6) && !long_trans);
        if (won) begin
          w = (ptr == 1) ? 1 : 0;
          chk("pick", {idle, pick1, pick0}, can_issue[w] ? (w ? 2 : 1) : 4);
          chk("follow", follow, 1);
          ptr = (w + 1) % 4;
          repeat (3) tick;
          if (can_issue[w]) begin
            chk("hold", {pick1, pick0, drive}, w ? 3'b101 : 3'b011);
            done[w] = 1'b1;
            tick;
            done = 2'b00;
            tick;
          end
          chk("release", {pick1, pick0, idle, drive}, 0);
        end
        repeat (4) tick;
      end
    end
    // exclusive request goes out one cycle later, then the peer joins
    excl = 2'b01;
    tick;
    chk("excl", x_out, 1);
    code = CODE_ATOMIC;
    want_excl = 1;
    repeat (8) tick;
    excl = 2'b00;
    want_excl = 0;
    repeat (8) tick;
    chk("excl_drop", x_out, 0);
    print_verdict;
  end
endmodule : tb_top
